/* hdl/aic_pkg.sv */
// Purpose : constants for the analog input converter control block
// Assumes : 50 MHz system clock, three serial converters on one board
// Notes   : register addresses are full byte addresses on the plain port
package aic_pkg;

  // ********************************
  // sizes
  // ********************************
  localparam int NUM_ADC       = 3;
  localparam int CH_PER_ADC    = 4;
  localparam int NUM_CH        = 12;
  localparam int NUM_PAIR      = 6;
  localparam int WORD_BITS     = 16;
  localparam int INIT_WORDS    = 2;
  localparam int READ_WORDS    = 8;
  localparam int READ_BITS     = 128;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_HALF     = 4;
  localparam int T_CONVST_NS   = 40;
  localparam int CONVST_CYC    = (T_CONVST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BUSY_WAIT_NS = 100;
  localparam int BUSY_WAIT_CYC = (T_BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************
  // register map
  // ********************************
  localparam logic [31:0] ADDR_OFFSET_FIRST = 32'h1000_6160;
  localparam logic [31:0] ADDR_OFFSET_LAST  = 32'h1000_6182;
  localparam logic [31:0] ADDR_OFFSET_STEP  = 32'h0000_0004;
  localparam logic [31:0] ADDR_CTRL         = 32'h1000_6190;
  localparam logic [31:0] ADDR_RANGE        = 32'h1000_6194;
  localparam logic [31:0] ADDR_OSR          = 32'h1000_6198;
  localparam logic [31:0] ADDR_STATUS       = 32'h1000_619C;
  localparam logic [31:0] ADDR_RESULT_BASE  = 32'h1000_61A0;

  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_TSEL_BIT    = 1;
  localparam int CTRL_START_BIT   = 2;
  localparam int STAT_INIT_BIT    = 0;
  localparam int STAT_CONV_BIT    = 1;
  localparam int STAT_ENABLE_BIT  = 2;

  localparam logic [7:0]  OFFSET_RESET = 8'h80;
  localparam logic [15:0] PAIR_RESET   = 16'h8080;
  localparam logic [3:0]  OSR_RESET    = 4'h0;
  localparam logic [3:0]  OSR_MAX      = 4'h8;

  // ********************************
  // converter frame: [15] write, [14:8] register, [7:0] data
  // ********************************
  localparam logic [6:0] ADC_REG_RANGE = 7'h01;
  localparam logic [6:0] ADC_REG_OSR   = 7'h02;
  localparam logic       ADC_WRITE     = 1'b1;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'b0_0000_0001,
    ST_INIT_LOAD = 9'b0_0000_0010,
    ST_INIT_SHFT = 9'b0_0000_0100,
    ST_READY     = 9'b0_0000_1000,
    ST_WAIT_PLS  = 9'b0_0001_0000,
    ST_CONVST    = 9'b0_0010_0000,
    ST_WAIT_BUSY = 9'b0_0100_0000,
    ST_READ_SHFT = 9'b0_1000_0000,
    ST_DELIVER   = 9'b1_0000_0000
  } aic_state_t;

endpackage : aic_pkg

/* hdl/aic_analog_input_ctrl.sv */
// Purpose : loads, starts and reads three serial converters of one board
// Assumes : converters clock data out on falling sclk, idle sclk low
// Notes   : averaging is done inside the converters; offset is added here
//
// Summary of operation
// - one shared clock and data out, one select line per converter
// - register writes go to converter 0, then 1, then 2
// - all three converters convert and read out together
// - a board enable permits or blocks all conversion activity
// - enable rising to 1 rewrites range and oversampling registers
// - register setup runs only while operating and enabled
// - software writes start after setup; only then conversions begin
// - timing select picks user pulse or timing generator pulse
// - results are read in step with the selected pulse
// - per channel the range picks current or voltage word
// - all twelve results appear together, with the single valid strobe unless a stop falls in the delivery cycle
// - results are 16-bit two's complement everywhere
// - each result is raw value plus signed channel offset
// - oversampling ratio programmed; converter returns the average
// - readout waits for busy to fall, however late
// - offset corrects at most 128 steps either way
// - offset is 8-bit offset binary, reset 80H meaning zero
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module aic_analog_input_ctrl
  import aic_pkg::*;
(
  input  wire  logic                         i_clock,
  input  wire  logic                         i_sys_rst,
  input  wire  logic                         i_run,
  input  wire  logic [31:0]                  i_reg_addr,
  input  wire  logic [31:0]                  i_reg_wdata,
  input  wire  logic                         i_reg_wr,
  input  wire  logic                         i_reg_rd,
  output logic [31:0]                        o_reg_rdata,
  input  wire  logic                         i_user_pulse,
  input  wire  logic                         i_sample_pulse,
  output logic                               o_sclk,
  output logic                               o_mosi,
  output logic [NUM_ADC-1:0]                 o_cs_n,
  output logic                               o_convst,
  input  wire  logic [NUM_ADC-1:0]           i_miso,
  input  wire  logic [NUM_ADC-1:0]           i_converter_busy_flag,
  output logic [NUM_CH-1:0][WORD_BITS-1:0]   o_channel_result,
  output logic                               o_result_valid_strobe
);

  // ********************************
  // decode helpers
  // ********************************
  function automatic logic [2:0] pair_index(input logic [31:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    for (int k = 0; k < NUM_PAIR - 1; k++) begin
      if (addr == ADDR_OFFSET_FIRST + ADDR_OFFSET_STEP * k) begin
        idx = 3'(k);
      end
    end
    if (addr == ADDR_OFFSET_LAST) begin
      idx = 3'(NUM_PAIR - 1);
    end
    return idx;
  endfunction : pair_index

  function automatic logic [4:0] result_index(input logic [31:0] addr);
    logic [4:0] idx;
    idx = 5'h1F;
    for (int k = 0; k < NUM_CH; k++) begin
      if (addr == ADDR_RESULT_BASE + ADDR_OFFSET_STEP * k) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction : result_index

  // ********************************
  // input synchronisers
  // ********************************
  logic [NUM_ADC-1:0] miso_s1_r;
  logic [NUM_ADC-1:0] miso_s2_r;
  logic [NUM_ADC-1:0] busy_s1_r;
  logic [NUM_ADC-1:0] busy_s2_r;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      miso_s1_r <= '0;
      miso_s2_r <= '0;
      busy_s1_r <= '0;
      busy_s2_r <= '0;
    end else begin
      miso_s1_r <= i_miso;
      miso_s2_r <= miso_s1_r;
      busy_s1_r <= i_converter_busy_flag;
      busy_s2_r <= busy_s1_r;
    end
  end

  // ********************************
  // registers
  // ********************************
  logic [NUM_PAIR-1:0][15:0] offset_pair_r;
  logic                      enable_r;
  logic                      tsel_r;
  logic                      start_r;
  logic [NUM_CH-1:0]         range_r;
  logic [3:0]                osr_r;
  logic                      init_done_r;
  aic_state_t                state_r;
  aic_state_t                state_nxt;
  logic [2:0]                wr_pair;

  assign wr_pair = pair_index(i_reg_addr);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      offset_pair_r <= {NUM_PAIR{PAIR_RESET}};
    end else if (i_reg_wr && wr_pair != 3'h7) begin
      offset_pair_r[wr_pair] <= i_reg_wdata[15:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      enable_r <= 1'b0;
      tsel_r   <= 1'b0;
      range_r  <= '0;
      osr_r    <= OSR_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_CTRL) begin
        enable_r <= i_reg_wdata[CTRL_ENABLE_BIT];
        tsel_r   <= i_reg_wdata[CTRL_TSEL_BIT];
      end
      if (i_reg_addr == ADDR_RANGE) begin
        range_r <= i_reg_wdata[NUM_CH-1:0];
      end
      if (i_reg_addr == ADDR_OSR) begin
        osr_r <= (i_reg_wdata[3:0] > OSR_MAX) ? OSR_MAX : i_reg_wdata[3:0];
      end
    end
  end

  // start flag, cleared when the board is disabled
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      start_r <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == ADDR_CTRL) begin
      start_r <= i_reg_wdata[CTRL_START_BIT] & i_reg_wdata[CTRL_ENABLE_BIT];
    end else if (!enable_r) begin
      start_r <= 1'b0;
    end
  end

  // ********************************
  // serial bit engine
  // ********************************
  logic [3:0]                  ph_r;
  logic [6:0]                  bit_r;
  logic [1:0]                  adc_r;
  logic                        word_r;
  logic [15:0]                 tx_r;
  logic [NUM_ADC-1:0][127:0]   rx_r;
  logic [3:0]                  wait_r;
  logic                        ph_last;
  logic                        ph_mid;
  logic                        bit_end;
  logic                        enable_d_r;
  logic                        enable_rise;
  logic                        active;
  logic                        pulse_sel;

  assign ph_last     = (ph_r == 4'(2 * SCLK_HALF - 1));
  assign ph_mid      = (ph_r == 4'(SCLK_HALF));
  assign enable_rise = enable_r & ~enable_d_r;
  assign active      = i_run & enable_r;
  assign pulse_sel   = tsel_r ? i_sample_pulse : i_user_pulse;
  assign bit_end     = ph_last && (state_r == ST_INIT_SHFT ? bit_r == 7'(WORD_BITS - 1)
                                                            : bit_r == 7'(READ_BITS - 1));

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ph_r  <= '0;
      bit_r <= '0;
    end else if (state_r == ST_INIT_SHFT || state_r == ST_READ_SHFT) begin
      ph_r <= ph_last ? 4'h0 : ph_r + 4'h1;
      if (ph_last) begin
        bit_r <= bit_end ? 7'h00 : bit_r + 7'h01;
      end
    end else begin
      ph_r  <= '0;
      bit_r <= '0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_sclk <= 1'b0;
    end else if (state_r == ST_INIT_SHFT || state_r == ST_READ_SHFT) begin
      o_sclk <= (ph_r >= 4'(SCLK_HALF - 1)) && !ph_last;
    end else begin
      o_sclk <= 1'b0;
    end
  end

  // frame holds range or oversampling setting
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_r   <= '0;
      o_mosi <= 1'b0;
    end else if (state_r == ST_INIT_LOAD) begin
      tx_r   <= word_r ? {ADC_WRITE, ADC_REG_OSR, 4'h0, osr_r}
                       : {ADC_WRITE, ADC_REG_RANGE, 4'h0, range_r[adc_r*CH_PER_ADC +: CH_PER_ADC]};
      o_mosi <= 1'b0;
    end else if (state_r == ST_INIT_SHFT && ph_r == 4'h0) begin
      o_mosi <= tx_r[WORD_BITS-1];
      tx_r   <= {tx_r[WORD_BITS-2:0], 1'b0};
    end else if (state_r != ST_INIT_SHFT) begin
      o_mosi <= 1'b0;
    end
  end

  // all three data lines captured together
  generate
    for (genvar a = 0; a < NUM_ADC; a++) begin : g_rx
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          rx_r[a] <= '0;
        end else if (state_r == ST_READ_SHFT && ph_mid) begin
          rx_r[a] <= {rx_r[a][READ_BITS-2:0], miso_s2_r[a]};
        end
      end
    end
  endgenerate

  // select one converter at a time during setup
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cs_n <= '1;
    end else if (state_r == ST_INIT_SHFT) begin
      o_cs_n <= ~(NUM_ADC'(1) << adc_r);
    end else if (state_r == ST_READ_SHFT) begin
      o_cs_n <= '0;
    end else begin
      o_cs_n <= '1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      adc_r  <= '0;
      word_r <= 1'b0;
    end else if (state_r == ST_IDLE || state_r == ST_READY) begin
      adc_r  <= '0;
      word_r <= 1'b0;
    end else if (state_r == ST_INIT_SHFT && bit_end) begin
      word_r <= ~word_r;
      if (word_r) begin
        adc_r <= adc_r + 2'h1;
      end
    end
  end

  // ********************************
  // sequencer
  // ********************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // setup only while operating and enabled
        if (active) begin
          state_nxt = ST_INIT_LOAD;
        end
      end
      ST_INIT_LOAD: begin
        state_nxt = ST_INIT_SHFT;
      end
      ST_INIT_SHFT: begin
        if (bit_end) begin
          state_nxt = (word_r && adc_r == 2'(NUM_ADC - 1)) ? ST_READY : ST_INIT_LOAD;
        end
      end
      ST_READY: begin
        if (start_r) begin
          state_nxt = ST_WAIT_PLS;
        end
      end
      ST_WAIT_PLS: begin
        if (!start_r) begin
          state_nxt = ST_READY;
        end else if (pulse_sel) begin
          state_nxt = ST_CONVST;
        end
      end
      ST_CONVST: begin
        if (wait_r == 4'(CONVST_CYC - 1)) begin
          state_nxt = ST_WAIT_BUSY;
        end
      end
      ST_WAIT_BUSY: begin
        // wait for busy to fall on all converters
        if (wait_r >= 4'(BUSY_WAIT_CYC) && busy_s2_r == '0) begin
          state_nxt = ST_READ_SHFT;
        end
      end
      ST_READ_SHFT: begin
        if (bit_end) begin
          state_nxt = ST_DELIVER;
        end
      end
      ST_DELIVER: begin
        state_nxt = ST_WAIT_PLS;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // stop drops everything; enable edge restarts setup
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else if (!active) begin
      state_r <= ST_IDLE;
    end else if (enable_rise) begin
      state_r <= ST_INIT_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      init_done_r <= 1'b0;
    end else if (!active || state_r == ST_INIT_LOAD) begin
      init_done_r <= 1'b0;
    end else if (state_r == ST_READY) begin
      init_done_r <= 1'b1;
    end
  end

  // pulses outside the wait state are not looked at
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wait_r <= '0;
    end else if (state_r == ST_CONVST || state_r == ST_WAIT_BUSY) begin
      wait_r <= (state_nxt != state_r) ? 4'h0 : (wait_r == 4'hF ? wait_r : wait_r + 4'h1);
    end else begin
      wait_r <= '0;
    end
  end

  // one start line for all three converters
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_convst <= 1'b0;
    end else begin
      o_convst <= (state_nxt == ST_CONVST) && active && !enable_rise;
    end
  end

  // ********************************
  // result path
  // ********************************
  logic [NUM_CH-1:0][WORD_BITS-1:0] corr;

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_corr
      localparam int A = c / CH_PER_ADC;
      localparam int K = c % CH_PER_ADC;
      logic signed [16:0] raw;
      logic signed [16:0] ofs;
      logic signed [16:0] sum;
      // range bit high picks the current word
      assign raw = 17'(signed'(range_r[c] ? rx_r[A][READ_BITS-1-WORD_BITS*(2*K+1) -: WORD_BITS]
                                          : rx_r[A][READ_BITS-1-WORD_BITS*(2*K)   -: WORD_BITS]));
      assign ofs = 17'(signed'({1'b0, offset_pair_r[c/2][(c%2)*8 +: 8]})) - 17'(signed'({1'b0, OFFSET_RESET}));
      assign sum = raw + ofs;
      assign corr[c] = (sum[16] != sum[15]) ? {sum[16], {15{~sum[16]}}} : sum[15:0];
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_channel_result <= '0;
    end else if (state_r == ST_DELIVER) begin
      o_channel_result <= corr;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_result_valid_strobe <= 1'b0;
    end else begin
      o_result_valid_strobe <= (state_r == ST_DELIVER) && active;
    end
  end

  // ********************************
  // register read
  // ********************************
  logic [2:0] rd_pair;
  logic [4:0] rd_res;

  assign rd_pair = pair_index(i_reg_addr);
  assign rd_res  = result_index(i_reg_addr);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= '0;
      if (rd_pair != 3'h7) begin
        o_reg_rdata[15:0] <= offset_pair_r[rd_pair];
      end else if (rd_res != 5'h1F) begin
        o_reg_rdata[15:0] <= o_channel_result[rd_res];
      end else if (i_reg_addr == ADDR_CTRL) begin
        o_reg_rdata[CTRL_ENABLE_BIT] <= enable_r;
        o_reg_rdata[CTRL_TSEL_BIT]   <= tsel_r;
        o_reg_rdata[CTRL_START_BIT]  <= start_r;
      end else if (i_reg_addr == ADDR_RANGE) begin
        o_reg_rdata[NUM_CH-1:0] <= range_r;
      end else if (i_reg_addr == ADDR_OSR) begin
        o_reg_rdata[3:0] <= osr_r;
      end else if (i_reg_addr == ADDR_STATUS) begin
        o_reg_rdata[STAT_INIT_BIT]   <= init_done_r;
        o_reg_rdata[STAT_CONV_BIT]   <= (state_r != ST_IDLE) && (state_r != ST_READY) && init_done_r;
        o_reg_rdata[STAT_ENABLE_BIT] <= enable_r;
      end
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule : aic_analog_input_ctrl
`default_nettype wire

/* testbench/aic_ctrl_props.sv */
// Purpose : concurrent checks on the converter control ports
// Assumes : one clock domain, synchronous active-high reset
// Notes   : bound to every instance of the control block
`timescale 1ns/1ps
`default_nettype none
module aic_ctrl_props
  import aic_pkg::*;
(
  input  wire logic                              i_clock,
  input  wire logic                              i_sys_rst,
  input  wire logic                              i_run,
  input  wire logic                              o_sclk,
  input  wire logic [NUM_ADC-1:0]                o_cs_n,
  input  wire logic                              o_convst,
  input  wire logic [NUM_ADC-1:0]                i_converter_busy_flag,
  input  wire logic [NUM_CH-1:0][WORD_BITS-1:0]  o_channel_result,
  input  wire logic                              o_result_valid_strobe
);
  // ********************************
  // port relations
  // ********************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  select_one_a: assert property (o_cs_n == 3'b000 || $onehot0(~o_cs_n))
    else $error("several selects low outside readout");
  sclk_idle_a: assert property (o_cs_n == 3'b111 |-> !o_sclk)
    else $error("serial clock high with no select");
  convst_len_a: assert property ($rose(o_convst) |=> o_convst ##1 !o_convst)
    else $error("conversion start not two cycles");
  convst_quiet_a: assert property (o_convst |-> o_cs_n == 3'b111)
    else $error("conversion start during a frame");
  read_wait_a: assert property ($rose(o_convst) |-> (o_cs_n == 3'b111) [*7])
    else $error("readout too soon after conversion start");
  busy_low_a: assert property ($rose(o_cs_n == 3'b000) |-> i_converter_busy_flag == 3'b000)
    else $error("readout began while busy");
  stop_idle_a: assert property (!$past(i_run) && !$past(i_run, 2) |-> o_cs_n == 3'b111 && !o_convst)
    else $error("link active while stopped");
  strobe_run_a: assert property (o_result_valid_strobe |-> $past(i_run))
    else $error("valid strobe while stopped");
  strobe_pulse_a: assert property (o_result_valid_strobe |=> !o_result_valid_strobe)
    else $error("valid strobe longer than one cycle");
  result_hold_a: assert property (!o_result_valid_strobe && !$past(i_sys_rst) |-> $stable(o_channel_result))
    else $error("results changed without strobe");
endmodule : aic_ctrl_props

bind aic_analog_input_ctrl aic_ctrl_props u_props (
  .i_clock               (i_clock),
  .i_sys_rst             (i_sys_rst),
  .i_run                 (i_run),
  .o_sclk                (o_sclk),
  .o_cs_n                (o_cs_n),
  .o_convst              (o_convst),
  .i_converter_busy_flag (i_converter_busy_flag),
  .o_channel_result      (o_channel_result),
  .o_result_valid_strobe (o_result_valid_strobe)
);
`default_nettype wire

/* testbench/aic_adc_model.sv */
// Purpose : behavioural model of the three serial converters of one board
// Assumes : data changes on falling sclk, frames bounded by select low
// Notes   : busy length grows with the programmed oversampling code
`timescale 1ns/1ps
`default_nettype none
module aic_adc_model
  import aic_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_sclk,
  input  wire logic                i_mosi,
  input  wire logic [NUM_ADC-1:0]  i_cs_n,
  input  wire logic                i_convst,
  output logic      [NUM_ADC-1:0]  o_miso,
  output logic      [NUM_ADC-1:0]  o_busy
);
  // ********************************
  // serial side
  // ********************************
  logic [15:0]  frame_log[$];
  int           conv_log[$];
  logic [15:0]  in_sr[NUM_ADC];
  int           in_cnt[NUM_ADC];
  logic [127:0] out_sr[NUM_ADC];
  logic [3:0]   osr_code = 4'h0;
  int           busy_cnt = 0;
  initial o_miso = '0;
  initial o_busy = '0;
  for (genvar k = 0; k < NUM_ADC; k++) begin : g_adc
    always @(negedge i_cs_n[k]) begin
      in_cnt[k] = 0;
      for (int w = 0; w < READ_WORDS; w++) begin
        out_sr[k][127-16*w -: 16] = 16'(32'hF000 + 32'h0123 * (8 * k + w));
      end
      o_miso[k] = out_sr[k][127];
    end
    always @(posedge i_sclk) if (!i_cs_n[k]) begin
      in_sr[k] = {in_sr[k][14:0], i_mosi};
      in_cnt[k]++;
    end
    always @(negedge i_sclk) if (!i_cs_n[k]) begin
      out_sr[k] = out_sr[k] << 1;
      o_miso[k] = out_sr[k][127];
    end
    // released line shows the inverse of its last bit
    always @(posedge i_cs_n[k]) begin
      o_miso[k] = ~o_miso[k];
      if (in_cnt[k] == 16) begin
        frame_log.push_back(in_sr[k]);
        conv_log.push_back(k);
        if (in_sr[k][14:8] == ADC_REG_OSR) osr_code = in_sr[k][3:0];
      end
    end
  end
  always @(posedge i_clock) begin
    if (i_convst && o_busy == '0) begin
      o_busy   <= '1;
      busy_cnt <= 20 << osr_code;
    end else if (busy_cnt > 1) begin
      busy_cnt <= busy_cnt - 1;
    end else begin
      o_busy   <= '0;
      busy_cnt <= 0;
    end
  end
endmodule : aic_adc_model
`default_nettype wire

/* testbench/tb_aic_analog_input_ctrl.sv */
// Purpose : self-checking bench for the converter control block
// Assumes : converter model on the serial link, pulses from the bench
// Notes   : one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_aic_analog_input_ctrl
  import aic_pkg::*;
  ;
  // ********************************
  // signals and helpers
  // ********************************
  logic                             i_clock, i_sys_rst, i_run, i_reg_wr, i_reg_rd, i_user_pulse, i_sample_pulse;
  logic [31:0]                      i_reg_addr, i_reg_wdata, reg_rdata;
  logic                             sclk, mosi, convst, strobe;
  logic [NUM_ADC-1:0]               cs_n, miso, busy;
  logic [NUM_CH-1:0][WORD_BITS-1:0] chan_res;
  logic [11:0]                      range_bits = 12'hA53;
  logic [7:0]                       off[NUM_CH];
  int                               err_total = 0;
  int                               samples_checked = 0;
  int                               strobe_cnt = 0;

  aic_analog_input_ctrl DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_run(i_run), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(reg_rdata),
    .i_user_pulse(i_user_pulse), .i_sample_pulse(i_sample_pulse), .o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n),
    .o_convst(convst), .i_miso(miso), .i_converter_busy_flag(busy), .o_channel_result(chan_res),
    .o_result_valid_strobe(strobe));
  aic_adc_model u_adc (.i_clock(i_clock), .i_sclk(sclk), .i_mosi(mosi), .i_cs_n(cs_n), .i_convst(convst),
    .o_miso(miso), .o_busy(busy));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic pulse(input bit user);
    @(posedge i_clock);
    if (user) i_user_pulse <= 1'b1;
    else i_sample_pulse <= 1'b1;
    @(posedge i_clock);
    i_user_pulse   <= 1'b0;
    i_sample_pulse <= 1'b0;
  endtask : pulse
  // counts strobes over a span, optionally stopping at the first
  task automatic watch(input int cyc, input bit early, output int seen);
    int n0;
    n0 = strobe_cnt;
    for (int i = 0; i < cyc && !(early && strobe_cnt != n0); i++) @(posedge i_clock);
    #1;
    seen = strobe_cnt - n0;
  endtask : watch
  function automatic logic [15:0] exp_res(input int c);
    return 16'hF000 + 16'h0123 * 16'(8 * (c / 4) + 2 * (c % 4) + range_bits[c]) + {8'h00, off[c]} - 16'h0080;
  endfunction : exp_res
  task automatic chk_frames(input int base);
    for (int i = 0; i < 2000 && u_adc.frame_log.size() < base + 6; i++) @(posedge i_clock);
    for (int k = 0; k < NUM_ADC; k++) begin
      `CHK(u_adc.conv_log[base+2*k], k)
      `CHK(u_adc.frame_log[base+2*k], {ADC_WRITE, ADC_REG_RANGE, 4'h0, range_bits[4*k +: 4]})
      `CHK(u_adc.frame_log[base+2*k+1], {ADC_WRITE, ADC_REG_OSR, 8'h03})
    end
  endtask : chk_frames

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    logic [31:0] d;
    rd(ADDR_OFFSET_FIRST, d);
    `CHK(d, 32'h0000_8080)
    rd(ADDR_OFFSET_LAST, d);
    `CHK(d, 32'h0000_8080)
    rd(32'h1000_6150, d);
    `CHK(d, 32'h0000_0000)
    `CHK(cs_n, 3'b111)
    $display("test reset done");
  endtask : t_reset
  task automatic t_setup();
    logic [31:0] d;
    int          n;
    wr(ADDR_RANGE, {20'h0, range_bits});
    wr(ADDR_OSR, 32'h0000_0003);
    wr(ADDR_OFFSET_FIRST, 32'h0000_FF00);
    wr(ADDR_OFFSET_LAST, 32'h0000_8162);
    off[0]  = 8'h00;
    off[1]  = 8'hFF;
    off[10] = 8'h62;
    off[11] = 8'h81;
    rd(ADDR_OFFSET_FIRST, d);
    `CHK(d, 32'h0000_FF00)
    wr(ADDR_CTRL, 32'h0000_0003);
    watch(1200, 1'b0, n);
    `CHK(u_adc.frame_log.size(), 0)
    @(posedge i_clock) i_run <= 1'b1;
    chk_frames(0);
    rd(ADDR_STATUS, d);
    `CHK(d, 32'h0000_0005)
    pulse(1'b0);
    watch(1500, 1'b0, n);
    `CHK(n, 0)
    $display("test setup done");
  endtask : t_setup
  task automatic t_convert();
    logic [31:0] d;
    int          n;
    wr(ADDR_CTRL, 32'h0000_0007);
    pulse(1'b1);
    watch(1500, 1'b0, n);
    `CHK(n, 0)
    pulse(1'b0);
    repeat (10) @(posedge i_clock);
    pulse(1'b0);
    watch(3000, 1'b1, n);
    `CHK(n, 1)
    for (int c = 0; c < NUM_CH; c++) `CHK(chan_res[c], exp_res(c))
    watch(1500, 1'b0, n);
    `CHK(n, 0)
    rd(ADDR_RESULT_BASE + 32'h0000_002C, d);
    `CHK(d[15:0], exp_res(11))
    wr(ADDR_CTRL, 32'h0000_0005);
    pulse(1'b1);
    watch(3000, 1'b1, n);
    `CHK(n, 1)
    $display("test convert done");
  endtask : t_convert
  task automatic t_disable();
    int n0;
    int bad;
    wr(ADDR_CTRL, 32'h0000_0000);
    pulse(1'b0);
    pulse(1'b1);
    n0  = strobe_cnt;
    bad = 0;
    repeat (1500) begin
      @(posedge i_clock);
      if (cs_n !== 3'b111) bad++;
    end
    `CHK(bad + strobe_cnt - n0, 0)
    wr(ADDR_CTRL, 32'h0000_0003);
    chk_frames(6);
    $display("test disable done");
  endtask : t_disable

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (40000) @(posedge i_clock);
    err_total++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {i_sys_rst, i_run, i_reg_wr, i_reg_rd, i_user_pulse, i_sample_pulse} = 6'h20;
    i_reg_addr  = 32'h0;
    i_reg_wdata = 32'h0;
    for (int c = 0; c < NUM_CH; c++) off[c] = 8'h80;
    repeat (20) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_setup();
    t_convert();
    t_disable();
    tally_and_finish();
  end
endmodule : tb_aic_analog_input_ctrl
`default_nettype wire
